// [src/cae_pkg.sv]
package cae_pkg;

  // operand addressing modes
  typedef enum logic [3:0] {
    INHERENT_MODE,
    BRANCH_OFFSET_MODE,
    INLINE_OPERAND_MODE,
    PAGE_ZERO_MODE,
    FULL_ADDRESS_MODE,
    INDEX_PLAIN_MODE,
    INDEX_POSTINC_MODE,
    INDEX_SHORT_OFFSET_MODE,
    INDEX_SHORT_OFFSET_POSTINC_MODE,
    INDEX_LONG_OFFSET_MODE,
    STACK_SHORT_OFFSET_MODE,
    STACK_LONG_OFFSET_MODE
  } cae_mode_t;

  // special operations reported at an instruction boundary
  typedef enum logic [2:0] {
    OP_NONE,
    OP_SOFTWARE_TRAP,
    OP_RETURN_FROM_INTERRUPT,
    OP_WAIT,
    OP_STOP,
    OP_DEBUG_HALT,
    OP_MASK_CLEAR,
    OP_MASK_SET
  } cae_op_t;

  // serial debug commands, already decoded
  typedef enum logic [2:0] {
    DBG_NONE,
    DBG_BACKGROUND,
    DBG_RESUME,
    DBG_SINGLE_STEP_CMD,
    DBG_TAGGED_RESUME_CMD
  } cae_dbg_t;

  // sequencer states
  typedef enum logic [3:0] {
    ST_RESET,
    ST_RUN,
    ST_FETCH,
    ST_PUSH,
    ST_VEC_HI,
    ST_VEC_LO,
    ST_FREE,
    ST_QUEUE,
    ST_PULL,
    ST_WAIT,
    ST_STOP,
    ST_BG
  } cae_state_t;

  // vector addresses
  localparam logic [15:0] VEC_RESET_ADDR   = 16'hfffe;
  localparam logic [15:0] VEC_TRAP_ADDR    = 16'hfffc;
  localparam logic [15:0] VEC_IRQ_TOP_ADDR = 16'hfffa;
  // address forming constants and the flag mask bit position
  localparam logic [7:0]  PAGE_ZERO_HIGH   = 8'h00;
  localparam logic [15:0] INDEX_STEP       = 16'h0001;
  localparam int          FLAG_MASK_BIT    = 3;
  // sequence counts, as last index
  localparam logic [2:0]  STACK_LAST       = 3'h4;
  localparam logic [2:0]  QUEUE_LAST       = 3'h2;
  // values after reset
  localparam logic [15:0] PC_RESET         = 16'h0000;
  localparam logic [15:0] SP_RESET         = 16'h00ff;
  localparam logic [15:0] HX_RESET         = 16'h0000;
  localparam logic [7:0]  FLAGS_RESET      = 8'h08;

endpackage

// [src/cae_ea_if.sv]
`timescale 1ns/1ps
interface cae_ea_if;
  import cae_pkg::*;
  cae_mode_t   mode;
  logic [15:0] hx;
  logic [15:0] sp;
  logic [15:0] pc;
  logic [15:0] opnd;
  logic        wide;
  logic [15:0] ea;
  logic [15:0] br_target;
  logic [15:0] hx_post;
  logic [1:0]  nbytes;
  logic        post_inc;

  modport calc (
    input  mode, hx, sp, pc, opnd, wide,
    output ea, br_target, hx_post, nbytes, post_inc
  );
  modport user (
    output mode, hx, sp, pc, opnd, wide,
    input  ea, br_target, hx_post, nbytes, post_inc
  );
endinterface

// [src/cae_ea_calc.sv]
`timescale 1ns/1ps
module cae_ea_calc
  import cae_pkg::*;
(
  // address request and result
  cae_ea_if.calc port
);

  logic [15:0] off8;
  logic [15:0] page0;

  // index and stack short offsets are unsigned; only the branch offset is sign-extended
  assign off8  = {8'h00, port.opnd[7:0]};
  assign page0 = {PAGE_ZERO_HIGH, port.opnd[7:0]};

  // operand byte count following the opcode
  assign port.nbytes =
    (port.mode == INLINE_OPERAND_MODE) ? (port.wide ? 2'h2 : 2'h1) :
    (port.mode == FULL_ADDRESS_MODE ||
     port.mode == INDEX_LONG_OFFSET_MODE ||
     port.mode == STACK_LONG_OFFSET_MODE) ? 2'h2 :
    (port.mode == BRANCH_OFFSET_MODE ||
     port.mode == PAGE_ZERO_MODE ||
     port.mode == INDEX_SHORT_OFFSET_MODE ||
     port.mode == INDEX_SHORT_OFFSET_POSTINC_MODE ||
     port.mode == STACK_SHORT_OFFSET_MODE) ? 2'h1 : 2'h0;

  // effective address selection per mode
  assign port.ea =
    (port.mode == PAGE_ZERO_MODE) ? page0 :
    (port.mode == FULL_ADDRESS_MODE) ? port.opnd :
    (port.mode == INDEX_PLAIN_MODE ||
     port.mode == INDEX_POSTINC_MODE) ? port.hx :
    (port.mode == INDEX_SHORT_OFFSET_MODE ||
     port.mode == INDEX_SHORT_OFFSET_POSTINC_MODE) ? port.hx + off8 :
    (port.mode == INDEX_LONG_OFFSET_MODE) ? port.hx + port.opnd :
    (port.mode == STACK_SHORT_OFFSET_MODE) ? port.sp + off8 :
    (port.mode == STACK_LONG_OFFSET_MODE) ? port.sp + port.opnd :
    16'h0000;

  assign port.br_target = port.pc + {{8{port.opnd[7]}}, port.opnd[7:0]};

  assign port.post_inc = (port.mode == INDEX_POSTINC_MODE) ||
                         (port.mode == INDEX_SHORT_OFFSET_POSTINC_MODE);
  assign port.hx_post  = port.hx + INDEX_STEP;

endmodule // cae_ea_calc

// [src/cae_irq_pick.sv]
`timescale 1ns/1ps
module cae_irq_pick
  import cae_pkg::*;
#(
  parameter int NUM_IRQ = 8
)
(
  // pending sources, bit 0 has top priority
  input  wire logic [NUM_IRQ-1:0] pend_i,
  // winner
  output logic                    any_o,
  output logic [15:0]             vec_o
);

  logic [NUM_IRQ:0] seen;
  logic [3:0]       sel [NUM_IRQ+1];

  // index is four bits wide, so sixteen sources at most
  if (NUM_IRQ < 1 || NUM_IRQ > 16) begin : g_bad
    $error("cae_irq_pick: NUM_IRQ out of range");
  end

  assign seen[0] = 1'b0;
  assign sel[0]  = 4'h0;

  // lowest set bit wins; later bits only fill the gap
  for (genvar i = 0; i < NUM_IRQ; i++) begin : g_pri
    assign seen[i+1] = seen[i] | pend_i[i];
    assign sel[i+1]  = seen[i] ? sel[i] : 4'(i);
  end

  assign any_o = seen[NUM_IRQ];
  assign vec_o = VEC_IRQ_TOP_ADDR - {11'h000, sel[NUM_IRQ], 1'b0};

endmodule // cae_irq_pick

// [src/cae_seq_top.sv]
`timescale 1ns/1ps
module cae_seq_top
  import cae_pkg::*;
#(
  parameter int NUM_IRQ = 8
)
(
  // clock, reset, enable
  input  wire logic               MCLK_I,
  input  wire logic               RESET_I,
  input  wire logic               CE_I,
  // reset event sources
  input  wire logic               POR_I,
  input  wire logic               ALIVE_WATCHDOG_I,
  input  wire logic               EXT_RESET_N_I,
  input  wire logic               SRC_CHECK_DONE_I,
  // system bus
  output logic [15:0]             BUS_ADDR_O,
  output logic [7:0]              BUS_WDATA_O,
  output logic                    BUS_RD_O,
  output logic                    BUS_WR_O,
  input  wire logic [7:0]         BUS_RDATA_I,
  // operand address command
  input  wire logic               CMD_VALID_I,
  input  wire cae_mode_t          CMD_MODE_I,
  input  wire logic               CMD_WIDE_I,
  input  wire logic               CMD_COND_I,
  output logic                    CMD_READY_O,
  output logic                    EA_VALID_O,
  output logic [15:0]             EA_O,
  output logic [15:0]             OPERAND_O,
  // instruction boundary
  input  wire logic               INSN_DONE_I,
  input  wire cae_op_t            SPECIAL_OP_I,
  // register file side
  input  wire logic [7:0]         ACC_I,
  input  wire logic [7:0]         FLAGS_I,
  input  wire logic               HX_LOAD_I,
  input  wire logic [15:0]        HX_I,
  input  wire logic               SP_LOAD_I,
  input  wire logic [15:0]        SP_I,
  output logic [15:0]             PC_O,
  output logic [15:0]             SP_O,
  output logic [15:0]             HX_O,
  output logic                    MASK_O,
  output logic [7:0]              FLAGS_O,
  output logic [7:0]              ACC_O,
  output logic                    RESTORE_O,
  output logic [7:0]              QUEUE_BYTE_O,
  output logic                    QUEUE_LOAD_O,
  // interrupt sources
  input  wire logic [NUM_IRQ-1:0] IRQ_PEND_I,
  // power and debug
  input  wire cae_dbg_t           DBG_CMD_I,
  input  wire logic               DEBUG_ENABLE_BIT_I,
  input  wire logic               STOP_KEEP_CLK_I,
  input  wire logic               PERIODIC_WAKE_I,
  output logic                    CPU_CLK_EN_O,
  output logic                    OSC_EN_O,
  output logic                    MIN_CLK_EN_O,
  output logic                    ACTIVE_BG_O
);

  cae_state_t  state_reg, state_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [15:0] pc_reg, pc_next;
  logic [15:0] sp_reg, sp_next;
  logic [15:0] hx_reg, hx_next;
  logic [15:0] vec_reg, vec_next;
  logic [15:0] opnd_reg, opnd_next;
  cae_mode_t   mode_reg, mode_next;
  logic        wide_reg, wide_next;
  logic        cond_reg, cond_next;
  logic        mask_reg, mask_next;
  logic        step_reg, step_next;
  logic [7:0]  flags_reg;
  logic [7:0]  acc_reg;
  logic        restore_reg;
  logic [15:0] ea_reg;
  logic [15:0] operand_reg;
  logic        ea_valid_reg;
  logic [7:0]  qbyte_reg;
  logic        qload_reg;

  logic        rst_evt;
  logic        reset_done;
  logic        in_run;
  logic        in_fetch;
  logic        take_cmd;
  logic        last_byte;
  logic        fin;
  logic        cond_now;
  logic        irq_any;
  logic [15:0] irq_vec;
  logic        irq_ok;
  logic        bg_cmd;
  logic        resume_cmd;
  logic [7:0]  push_data;

  cae_ea_if u_ea_if ();

  cae_ea_calc u_ea (
    .port (u_ea_if.calc)
  );

  cae_irq_pick #(
    .NUM_IRQ (NUM_IRQ)
  ) u_pick (
    .pend_i (IRQ_PEND_I),
    .any_o  (irq_any),
    .vec_o  (irq_vec)
  );

  // reset sources act in any state
  assign rst_evt    = POR_I | ALIVE_WATCHDOG_I | ~EXT_RESET_N_I;
  assign reset_done = ~rst_evt & SRC_CHECK_DONE_I;

  // status decode
  assign in_run     = (state_reg == ST_RUN);
  assign in_fetch   = (state_reg == ST_FETCH);
  assign take_cmd   = in_run & CMD_VALID_I & ~INSN_DONE_I;
  // mask bit gates every maskable source
  assign irq_ok     = irq_any & ~mask_reg;
  assign bg_cmd     = (DBG_CMD_I == DBG_BACKGROUND);
  assign resume_cmd = (DBG_CMD_I == DBG_RESUME) ||
                      (DBG_CMD_I == DBG_SINGLE_STEP_CMD) ||
                      (DBG_CMD_I == DBG_TAGGED_RESUME_CMD);

  // the calculator sees the newest byte in the cycle it arrives
  assign u_ea_if.mode = in_run ? CMD_MODE_I : mode_reg;
  assign u_ea_if.wide = in_run ? CMD_WIDE_I : wide_reg;
  assign u_ea_if.hx   = hx_reg;
  assign u_ea_if.sp   = sp_reg;
  // pc already past the last branch byte
  assign u_ea_if.pc   = in_fetch ? pc_reg + 16'h0001 : pc_reg;
  // bytes shift in, first byte ends up high
  assign u_ea_if.opnd = in_fetch ? {opnd_reg[7:0], BUS_RDATA_I} : 16'h0000;
  assign cond_now     = in_run ? CMD_COND_I : cond_reg;

  // zero-byte modes finish without a bus cycle
  assign last_byte = in_fetch && (cnt_reg == {1'b0, u_ea_if.nbytes - 2'h1});
  assign fin       = (take_cmd && u_ea_if.nbytes == 2'h0) || last_byte;

  // push order pc low, pc high, x, acc, flags
  // index high byte left off the stack
  assign push_data =
    (cnt_reg == 3'h0) ? pc_reg[7:0] :
    (cnt_reg == 3'h1) ? pc_reg[15:8] :
    (cnt_reg == 3'h2) ? hx_reg[7:0] :
    (cnt_reg == 3'h3) ? ACC_I :
    {FLAGS_I[7:4], mask_reg, FLAGS_I[2:0]};

  // bus strobes; reads expect data in the same cycle
  assign BUS_RD_O    = in_fetch || state_reg == ST_VEC_HI ||
                       state_reg == ST_VEC_LO || state_reg == ST_QUEUE ||
                       state_reg == ST_PULL;
  assign BUS_WR_O    = (state_reg == ST_PUSH);
  assign BUS_WDATA_O = BUS_WR_O ? push_data : 8'h00;
  assign BUS_ADDR_O  =
    (in_fetch || state_reg == ST_QUEUE) ? pc_reg :
    (state_reg == ST_VEC_HI) ? vec_reg :
    (state_reg == ST_VEC_LO) ? vec_reg + 16'h0001 :
    (state_reg == ST_PUSH) ? sp_reg :
    (state_reg == ST_PULL) ? sp_reg + 16'h0001 :
    16'h0000;

  // sequencer next state and working registers
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    pc_next    = pc_reg;
    sp_next    = sp_reg;
    hx_next    = hx_reg;
    vec_next   = vec_reg;
    opnd_next  = opnd_reg;
    mode_next  = mode_reg;
    wide_next  = wide_reg;
    cond_next  = cond_reg;
    mask_next  = mask_reg;
    step_next  = step_reg;
    if (in_run && HX_LOAD_I)
      hx_next = HX_I;
    if (in_run && SP_LOAD_I)
      sp_next = SP_I;
    case (state_reg)
      ST_RESET:
        // vector from the reset slot, then queue fill
        if (reset_done)
        begin
          state_next = ST_VEC_HI;
          vec_next   = VEC_RESET_ADDR;
          mask_next  = 1'b1;
          sp_next    = SP_RESET;
          step_next  = 1'b0;
        end
      ST_RUN:
        if (INSN_DONE_I)
        begin
          cnt_next = 3'h0;
          if (step_reg)
          begin
            state_next = ST_BG;
            step_next  = 1'b0;
          end
          else if (SPECIAL_OP_I == OP_SOFTWARE_TRAP)
          begin
            state_next = ST_PUSH;
            vec_next   = VEC_TRAP_ADDR;
          end
          else if (SPECIAL_OP_I == OP_RETURN_FROM_INTERRUPT)
            state_next = ST_PULL;
          // wait opens the mask and halts the cpu clock
          else if (SPECIAL_OP_I == OP_WAIT)
          begin
            mask_next  = 1'b0;
            state_next = ST_WAIT;
          end
          else if (SPECIAL_OP_I == OP_STOP)
            state_next = ST_STOP;
          else if (SPECIAL_OP_I == OP_DEBUG_HALT)
            state_next = ST_BG;
          else if (SPECIAL_OP_I == OP_MASK_CLEAR)
            mask_next = 1'b0;
          else if (SPECIAL_OP_I == OP_MASK_SET)
            mask_next = 1'b1;
          else if (bg_cmd)
            state_next = ST_BG;
          else if (irq_ok)
          begin
            state_next = ST_PUSH;
            vec_next   = irq_vec;
          end
        end
        else if (take_cmd)
        begin
          mode_next = CMD_MODE_I;
          wide_next = CMD_WIDE_I;
          cond_next = CMD_COND_I;
          opnd_next = 16'h0000;
          cnt_next  = 3'h0;
          if (u_ea_if.nbytes != 2'h0)
            state_next = ST_FETCH;
        end
      ST_FETCH:
      begin
        pc_next   = pc_reg + 16'h0001;
        opnd_next = u_ea_if.opnd;
        cnt_next  = cnt_reg + 3'h1;
        if (last_byte)
          state_next = ST_RUN;
      end
      ST_PUSH:
      begin
        sp_next  = sp_reg - 16'h0001;
        cnt_next = cnt_reg + 3'h1;
        // mask set once flags are stacked
        if (cnt_reg == STACK_LAST)
        begin
          mask_next  = 1'b1;
          state_next = ST_VEC_HI;
        end
      end
      // vector halves, free cycle, queue refill
      ST_VEC_HI:
      begin
        pc_next    = {BUS_RDATA_I, pc_reg[7:0]};
        state_next = ST_VEC_LO;
      end
      ST_VEC_LO:
      begin
        pc_next    = {pc_reg[15:8], BUS_RDATA_I};
        state_next = ST_FREE;
      end
      ST_FREE:
      begin
        cnt_next   = 3'h0;
        state_next = ST_QUEUE;
      end
      ST_QUEUE:
      begin
        pc_next  = pc_reg + 16'h0001;
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == QUEUE_LAST)
          state_next = ST_RUN;
      end
      ST_PULL:
      begin
        // flags, acc, x, pc high, pc low
        sp_next  = sp_reg + 16'h0001;
        cnt_next = cnt_reg + 3'h1;
        if (cnt_reg == 3'h0)
          mask_next = BUS_RDATA_I[FLAG_MASK_BIT];
        if (cnt_reg == 3'h2)
          hx_next = {hx_reg[15:8], BUS_RDATA_I};
        if (cnt_reg == 3'h3)
          pc_next = {BUS_RDATA_I, pc_reg[7:0]};
        if (cnt_reg == 3'h4)
          pc_next = {pc_reg[15:8], BUS_RDATA_I};
        if (cnt_reg == STACK_LAST)
        begin
          cnt_next   = 3'h0;
          state_next = ST_QUEUE;
        end
      end
      ST_WAIT:
        // host can still reach a waiting core
        if (bg_cmd)
          state_next = ST_BG;
        else if (irq_ok)
        begin
          cnt_next   = 3'h0;
          vec_next   = irq_vec;
          state_next = ST_PUSH;
        end
      ST_STOP:
        // only a live oscillator can hear the host
        if (DEBUG_ENABLE_BIT_I && bg_cmd)
          state_next = ST_BG;
        else if (irq_ok)
        begin
          cnt_next   = 3'h0;
          vec_next   = irq_vec;
          state_next = ST_PUSH;
        end
        // periodic wake needs the kept clocks
        else if (STOP_KEEP_CLK_I && PERIODIC_WAKE_I)
          state_next = ST_RUN;
      ST_BG:
        if (resume_cmd)
        begin
          state_next = ST_RUN;
          step_next  = (DBG_CMD_I == DBG_SINGLE_STEP_CMD);
        end
      default:
        state_next = ST_RESET;
    endcase
    if (fin && u_ea_if.mode == BRANCH_OFFSET_MODE && cond_now)
      pc_next = u_ea_if.br_target;
    // index pair steps past the operand
    if (fin && u_ea_if.post_inc)
      hx_next = u_ea_if.hx_post;
    if (rst_evt)
      state_next = ST_RESET;
  end

  // sequencer state
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      state_reg <= ST_RESET;
      cnt_reg   <= 3'h0;
      mask_reg  <= FLAGS_RESET[FLAG_MASK_BIT];
      step_reg  <= 1'b0;
    end
    else if (CE_I)
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      mask_reg  <= mask_next;
      step_reg  <= step_next;
    end
  end

  // address registers and latched command
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      pc_reg   <= PC_RESET;
      sp_reg   <= SP_RESET;
      hx_reg   <= HX_RESET;
      vec_reg  <= VEC_RESET_ADDR;
      opnd_reg <= 16'h0000;
      mode_reg <= INHERENT_MODE;
      wide_reg <= 1'b0;
      cond_reg <= 1'b0;
    end
    else if (CE_I)
    begin
      pc_reg   <= pc_next;
      sp_reg   <= sp_next;
      hx_reg   <= hx_next;
      vec_reg  <= vec_next;
      opnd_reg <= opnd_next;
      mode_reg <= mode_next;
      wide_reg <= wide_next;
      cond_reg <= cond_next;
    end
  end

  // result values held until replaced; valid and restore strobes last one cycle, queue load stays high through all three queue reads
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      ea_valid_reg <= 1'b0;
      ea_reg       <= 16'h0000;
      operand_reg  <= 16'h0000;
      qload_reg    <= 1'b0;
      qbyte_reg    <= 8'h00;
      restore_reg  <= 1'b0;
    end
    else if (CE_I)
    begin
      ea_valid_reg <= fin;
      if (fin)
        ea_reg <= u_ea_if.ea;
      if (fin)
        operand_reg <= u_ea_if.opnd;
      qload_reg   <= (state_reg == ST_QUEUE);
      if (state_reg == ST_QUEUE)
        qbyte_reg <= BUS_RDATA_I;
      restore_reg <= (state_reg == ST_PULL) && (cnt_reg == STACK_LAST);
    end
  end

  // pulled accumulator and flags
  always_ff @(posedge MCLK_I)
  begin
    if (RESET_I)
    begin
      flags_reg <= FLAGS_RESET;
      acc_reg   <= 8'h00;
    end
    else if (CE_I && state_reg == ST_PULL)
    begin
      if (cnt_reg == 3'h0)
        flags_reg <= BUS_RDATA_I;
      if (cnt_reg == 3'h1)
        acc_reg <= BUS_RDATA_I;
    end
  end

  // outputs; cpu clock gate is a plain state decode, oscillator and minimal clock gates also follow their enables
  assign CMD_READY_O  = in_run;
  assign EA_VALID_O   = ea_valid_reg;
  assign EA_O         = ea_reg;
  assign OPERAND_O    = operand_reg;
  assign PC_O         = pc_reg;
  assign SP_O         = sp_reg;
  assign HX_O         = hx_reg;
  assign MASK_O       = mask_reg;
  assign FLAGS_O      = {flags_reg[7:4], mask_reg, flags_reg[2:0]};
  assign ACC_O        = acc_reg;
  assign RESTORE_O    = restore_reg;
  assign QUEUE_BYTE_O = qbyte_reg;
  assign QUEUE_LOAD_O = qload_reg;
  assign CPU_CLK_EN_O = (state_reg != ST_WAIT) && (state_reg != ST_STOP);
  assign OSC_EN_O     = (state_reg != ST_STOP) || DEBUG_ENABLE_BIT_I;
  assign MIN_CLK_EN_O = (state_reg != ST_STOP) || STOP_KEEP_CLK_I;
  assign ACTIVE_BG_O  = (state_reg == ST_BG);

endmodule // cae_seq_top

// [verification/cae_mem_model.sv]
`timescale 1ns/1ps
module cae_mem_model
(
  // core bus
  input  wire logic        clk_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        rd_i,
  input  wire logic        wr_i,
  // same-cycle read data
  output logic [7:0]       rdata_o
);
  logic [7:0] mem_reg [0:65535];
  logic [7:0] last_reg = 8'h00;
  // idle bus shows the inverse of the last byte, not a stale copy
  assign rdata_o = rd_i ? mem_reg[addr_i] : ~last_reg;
  // plain always so the bench may preload bytes
  always @(posedge clk_i)
  begin
    if (wr_i)
      mem_reg[addr_i] <= wdata_i;
    if (rd_i)
      last_reg <= mem_reg[addr_i];
  end
  // each byte holds its low address, so no read is unknown
  initial
    for (int i = 0; i < 65536; i++)
      mem_reg[i] = i[7:0];
endmodule // cae_mem_model

// [verification/cae_seq_top_assertions.sv]
`timescale 1ns/1ps
module cae_seq_top_assertions
  import cae_pkg::*;
(
  // watched ports
  input wire logic        MCLK_I,
  input wire logic        RESET_I,
  input wire logic        EXT_RESET_N_I,
  input wire logic [15:0] BUS_ADDR_O,
  input wire logic        BUS_RD_O,
  input wire logic        BUS_WR_O,
  input wire logic        CMD_VALID_I,
  input wire cae_mode_t   CMD_MODE_I,
  input wire logic        CMD_READY_O,
  input wire logic        EA_VALID_O,
  input wire logic [15:0] EA_O,
  input wire logic [15:0] OPERAND_O,
  input wire logic        INSN_DONE_I,
  input wire cae_op_t     SPECIAL_OP_I,
  input wire logic [15:0] HX_O,
  input wire logic        MASK_O,
  input wire logic        ACTIVE_BG_O,
  input wire cae_dbg_t    DBG_CMD_I
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);
  // taken command and trap boundary
  wire take = CMD_VALID_I && CMD_READY_O && !INSN_DONE_I;
  wire trap = INSN_DONE_I && CMD_READY_O && SPECIAL_OP_I == OP_SOFTWARE_TRAP;
  sequence s_vec;
    BUS_RD_O && BUS_ADDR_O == 16'hffff ##1 !BUS_RD_O ##1 BUS_RD_O [*3];
  endsequence
  sequence s_push;
    BUS_WR_O [*5] ##1 BUS_RD_O && BUS_ADDR_O == 16'hfffc;
  endsequence
  property p_vec;
    BUS_RD_O && BUS_ADDR_O == 16'hfffe |=> s_vec;
  endproperty
  a_vec: assert property (p_vec) else $error("vector order");
  property p_ext;
    !EXT_RESET_N_I |=> !CMD_READY_O && !BUS_RD_O && !BUS_WR_O;
  endproperty
  a_ext: assert property (p_ext) else $error("reset late");
  property p_inh;
    take && CMD_MODE_I == INHERENT_MODE |=> EA_VALID_O && !BUS_RD_O;
  endproperty
  a_inh: assert property (p_inh) else $error("inherent bus");
  property p_pz;
    take && CMD_MODE_I == PAGE_ZERO_MODE |=> ##1 EA_O == OPERAND_O;
  endproperty
  a_pz: assert property (p_pz) else $error("page zero");
  property p_ix;
    take && CMD_MODE_I == INDEX_PLAIN_MODE |=> EA_O == $past(HX_O);
  endproperty
  a_ix: assert property (p_ix) else $error("index plain");
  property p_inc;
    take && CMD_MODE_I == INDEX_POSTINC_MODE |=> HX_O == EA_O + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("post inc");
  property p_trap;
    trap |=> s_push ##1 BUS_ADDR_O == 16'hfffd && MASK_O ##1 !BUS_RD_O;
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry");
  property p_bg;
    ACTIVE_BG_O && DBG_CMD_I == DBG_NONE && EXT_RESET_N_I |=> ACTIVE_BG_O;
  endproperty
  a_bg: assert property (p_bg) else $error("left halt");
endmodule // cae_seq_top_assertions

// [verification/cae_seq_top_tb.sv]
`timescale 1ns/1ps
bind cae_seq_top cae_seq_top_assertions cae_seq_top_assertions_i (.*);
module cae_seq_top_tb;
  import cae_pkg::*;
  // inputs, set at time zero
  logic        MCLK_I = 1'b0, RESET_I = 1'b1, CE_I = 1'b1, POR_I = 1'b0;
  logic        ALIVE_WATCHDOG_I = 1'b0, EXT_RESET_N_I = 1'b1;
  logic        SRC_CHECK_DONE_I = 1'b0, DEBUG_ENABLE_BIT_I = 1'b0;
  logic        STOP_KEEP_CLK_I = 1'b0, PERIODIC_WAKE_I = 1'b0;
  logic        CMD_VALID_I = 1'b0, CMD_WIDE_I = 1'b0, CMD_COND_I = 1'b0;
  logic        INSN_DONE_I = 1'b0, HX_LOAD_I = 1'b0, SP_LOAD_I = 1'b0;
  cae_mode_t   CMD_MODE_I = INHERENT_MODE;
  cae_op_t     SPECIAL_OP_I = OP_NONE;
  cae_dbg_t    DBG_CMD_I = DBG_NONE;
  logic [7:0]  ACC_I = 8'h5e, FLAGS_I = 8'h00, IRQ_PEND_I = 8'h00;
  logic [15:0] HX_I = 16'h0300, SP_I = 16'h0200, pc0, sp0;
  // outputs
  logic [15:0] BUS_ADDR_O, EA_O, OPERAND_O, PC_O, SP_O, HX_O;
  logic [7:0]  BUS_WDATA_O, BUS_RDATA_I, FLAGS_O, ACC_O, QUEUE_BYTE_O;
  logic        BUS_RD_O, BUS_WR_O, CMD_READY_O, EA_VALID_O, MASK_O;
  logic        RESTORE_O, QUEUE_LOAD_O, CPU_CLK_EN_O, OSC_EN_O;
  logic        MIN_CLK_EN_O, ACTIVE_BG_O;
  int          bad_count = 0, checked = 0;
  cae_seq_top cae_seq_top_i (.*);
  cae_mem_model cae_mem_model_i (.clk_i(MCLK_I), .addr_i(BUS_ADDR_O),
    .wdata_i(BUS_WDATA_O), .rd_i(BUS_RD_O), .wr_i(BUS_WR_O),
    .rdata_o(BUS_RDATA_I));
  // bench clock
  always #2.5 MCLK_I = ~MCLK_I;
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // bounded wait for ready, or for a result when ea is set
  task automatic wait_on(bit ea);
    int n;
    n = 0;
    while ((ea ? EA_VALID_O : CMD_READY_O) !== 1'b1)
    begin
      @(posedge MCLK_I);
      #1;
      n++;
      if (n > 100)
      begin
        bad_count++;
        close_out();
      end
    end
  endtask
  // one command, two program bytes preloaded at the pc
  task automatic cmd(cae_mode_t m, logic w, logic c, logic [15:0] b);
    wait_on(1'b0);
    pc0 = PC_O;
    cae_mem_model_i.mem_reg[pc0] = b[15:8];
    cae_mem_model_i.mem_reg[pc0 + 16'h0001] = b[7:0];
    @(posedge MCLK_I);
    CMD_VALID_I <= 1'b1;
    CMD_MODE_I <= m;
    CMD_WIDE_I <= w;
    CMD_COND_I <= c;
    @(posedge MCLK_I);
    CMD_VALID_I <= 1'b0;
    #1;
    wait_on(1'b1);
  endtask
  // one boundary carrying a special operation
  task automatic bnd(cae_op_t op);
    wait_on(1'b0);
    @(posedge MCLK_I);
    INSN_DONE_I <= 1'b1;
    SPECIAL_OP_I <= op;
    @(posedge MCLK_I);
    INSN_DONE_I <= 1'b0;
    SPECIAL_OP_I <= OP_NONE;
    #1;
  endtask
  // every mode but short offset post-increment and long stack offset, against hx 0300 and sp 0200
  task automatic t_modes;
    cmd(FULL_ADDRESS_MODE, 1'b0, 1'b0, 16'h1234);
    chk("full", EA_O, 16'h1234);
    cmd(INLINE_OPERAND_MODE, 1'b1, 1'b0, 16'habcd);
    chk("inline", OPERAND_O, 16'habcd);
    cmd(PAGE_ZERO_MODE, 1'b0, 1'b0, 16'h9c00);
    chk("page0", EA_O, 16'h009c);
    cmd(INDEX_PLAIN_MODE, 1'b0, 1'b0, 16'h0000);
    chk("hx", EA_O, 16'h0300);
    cmd(INDEX_SHORT_OFFSET_MODE, 1'b0, 1'b0, 16'hf000);
    chk("hx_byte", EA_O, 16'h03f0);
    cmd(INDEX_LONG_OFFSET_MODE, 1'b0, 1'b0, 16'h1234);
    chk("hx_word", EA_O, 16'h1534);
    cmd(STACK_SHORT_OFFSET_MODE, 1'b0, 1'b0, 16'hff00);
    chk("sp_byte", EA_O, 16'h02ff);
    cmd(BRANCH_OFFSET_MODE, 1'b0, 1'b1, 16'h8000);
    chk("branch", PC_O, pc0 + 16'hff81);
    cmd(INHERENT_MODE, 1'b0, 1'b0, 16'h0000);
    chk("inherent", PC_O, pc0);
    cmd(INDEX_POSTINC_MODE, 1'b0, 1'b0, 16'h0000);
    chk("postinc", HX_O, 16'h0301);
  endtask
  // wait opens the mask; an interrupt wakes and stacks five bytes
  task automatic t_wait;
    sp0 = SP_O;
    bnd(OP_WAIT);
    chk("clk", CPU_CLK_EN_O, 16'h0000);
    chk("mask", MASK_O, 16'h0000);
    @(posedge MCLK_I);
    IRQ_PEND_I <= 8'h04;
    wait_on(1'b0);
    chk("sp", SP_O, sp0 - 16'h0005);
    chk("x", cae_mem_model_i.mem_reg[sp0 - 16'h0002], 16'h0001);
    @(posedge MCLK_I);
    IRQ_PEND_I <= 8'h00;
  endtask
  // trap runs with the mask set; return unstacks it
  task automatic t_trap;
    sp0 = SP_O;
    bnd(OP_SOFTWARE_TRAP);
    wait_on(1'b0);
    chk("sp", SP_O, sp0 - 16'h0005);
    bnd(OP_RETURN_FROM_INTERRUPT);
    wait_on(1'b0);
    chk("sp", SP_O, sp0);
    chk("acc", ACC_O, 16'h005e);
  endtask
  // halt parks the core until resume; external reset then restarts it
  task automatic t_halt;
    bnd(OP_DEBUG_HALT);
    chk("bg", ACTIVE_BG_O, 16'h0001);
    @(posedge MCLK_I);
    DBG_CMD_I <= DBG_RESUME;
    DEBUG_ENABLE_BIT_I <= 1'b1;
    @(posedge MCLK_I);
    DBG_CMD_I <= DBG_NONE;
    EXT_RESET_N_I <= 1'b0;
    #1;
    chk("bg", ACTIVE_BG_O, 16'h0000);
    @(posedge MCLK_I);
    EXT_RESET_N_I <= 1'b1;
    // let the reset edge settle, or the old run state reads as ready
    #1;
    wait_on(1'b0);
    chk("sp", SP_O, 16'h00ff);
  endtask
  // stop with debug enabled: periodic wake, then host takes the core
  task automatic t_stop;
    bnd(OP_STOP);
    chk("osc", OSC_EN_O, 16'h0001);
    chk("min", MIN_CLK_EN_O, 16'h0000);
    @(posedge MCLK_I);
    STOP_KEEP_CLK_I <= 1'b1;
    PERIODIC_WAKE_I <= 1'b1;
    @(posedge MCLK_I);
    PERIODIC_WAKE_I <= 1'b0;
    #1;
    chk("wake", CMD_READY_O, 16'h0001);
    bnd(OP_STOP);
    @(posedge MCLK_I);
    DBG_CMD_I <= DBG_BACKGROUND;
    @(posedge MCLK_I);
    DBG_CMD_I <= DBG_NONE;
    #1;
    chk("bg", ACTIVE_BG_O, 16'h0001);
  endtask
  // reset, register loads, then the scenarios
  initial
  begin
    repeat (6) @(posedge MCLK_I);
    RESET_I <= 1'b0;
    SRC_CHECK_DONE_I <= 1'b1;
    wait_on(1'b0);
    chk("flags", FLAGS_O, 16'h0008);
    @(posedge MCLK_I);
    HX_LOAD_I <= 1'b1;
    SP_LOAD_I <= 1'b1;
    @(posedge MCLK_I);
    HX_LOAD_I <= 1'b0;
    SP_LOAD_I <= 1'b0;
    t_modes();
    t_wait();
    t_trap();
    t_halt();
    t_stop();
    close_out();
  end
endmodule // cae_seq_top_tb
